// [shared/mbd_consts.svh]
// constants of the multiphase buck voltage control block
// assumes a 125 MHz core clock and a byte-addressed wishbone slave
`ifndef MBD_CONSTS_SVH
`define MBD_CONSTS_SVH

// register byte offsets
`define MBD_OFS_TARGET_A   8'h00
`define MBD_OFS_TARGET_B   8'h04
`define MBD_OFS_CFG_MAIN   8'h08
`define MBD_OFS_CFG_ONE    8'h0C
`define MBD_OFS_CFG_TWO    8'h10
`define MBD_OFS_OSC_TRIM   8'h14
`define MBD_OFS_AUTO_TH    8'h18
`define MBD_OFS_CEILING    8'h1C
`define MBD_OFS_STATUS     8'h20

// field positions
`define MBD_TV_LP_BIT      8
`define MBD_CM_SEL_BIT     0
`define MBD_CM_SRC_BIT     1
`define MBD_CM_DONE_EN_BIT 2
`define MBD_CM_P3_OUT_BIT  3
`define MBD_CM_P4_CLK_BIT  4

// reset values
`define MBD_RST_CFG_MAIN   5'h00
`define MBD_RST_CFG_ONE    4'h1
`define MBD_RST_CFG_TWO    2'h2
`define MBD_RST_TRIM       5'h00
`define MBD_RST_AUTO_TH    8'h50
`define MBD_RST_CEILING    8'hFF

// timing and scaling
`define MBD_CLK_MHZ        125
`define MBD_STEP_NS_0      4000
`define MBD_STEP_NS_1      2000
`define MBD_STEP_NS_2      1000
`define MBD_STEP_NS_3      500
`define MBD_STEP_MV        10
`define MBD_CODE_MV        10
`define MBD_OSC_NOM_KHZ    6000
`define MBD_OSC_STEP_KHZ   180
`define MBD_SW_STEP_KHZ    90
`define MBD_DEV_PHASES     4
`define MBD_DUAL_MAX_PHASES 8

`endif

// [shared/mbd_pkg.sv]
// types shared by the multiphase buck voltage control block
// assumes the constants header is included by the users
package mbd_pkg;

  typedef enum logic [1:0] {
    MBD_MODE_PER_SETTING,
    MBD_MODE_NORMAL,
    MBD_MODE_LOW_POWER,
    MBD_MODE_AUTO
  } mbd_mode_type;

  typedef enum logic [1:0] {
    MBD_PH_ONE,
    MBD_PH_TWO,
    MBD_PH_FOUR,
    MBD_PH_AUTO
  } mbd_phase_type;

  typedef struct packed {
    logic [8:0]  tva;
    logic [8:0]  tvb;
    logic [4:0]  cfg_main;
    logic [3:0]  cfg_one;
    logic [1:0]  cfg_two;
    logic [4:0]  trim;
    logic [7:0]  auto_th;
    logic [7:0]  ceil;
    logic        otp_done;
    logic [1:0]  lp_phases;
    logic        sel;
    logic [7:0]  ramp;
    logic        ramping;
    logic        done;
    logic        p3;
    logic        p3_oe;
    logic        pwm;
    logic        lp;
    logic [3:0]  phases;
    logic        ext;
    logic        p4_prev;
    logic        ext_alive;
    logic [13:0] osc_khz;
    logic [13:0] sw_khz;
    logic        ack;
    logic [31:0] dat;
  } mbd_state_type;

endpackage

// [hw/mbd_sync.sv]
// two-flop synchroniser for asynchronous pin levels
// assumes levels only; pulses shorter than two clocks may be missed
`timescale 1ns/10ps
module mbd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } s_q, s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.sync;
endmodule

// [hw/mbd_step_timer.sv]
// ramp step interval timer, one tick per programmed interval
// assumes restart_i is a same-clock pulse that aligns the interval
`timescale 1ns/10ps
`include "mbd_consts.svh"
module mbd_step_timer #(
  parameter int CNT_W = 10
) (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       restart_i,
  input  wire logic [1:0] speed_i,
  output logic            tick_o
);
  // intervals round up to whole cycles (0.5 us gives 63)
  localparam logic [CNT_W-1:0] C0 =
    CNT_W'((`MBD_STEP_NS_0 * `MBD_CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] C1 =
    CNT_W'((`MBD_STEP_NS_1 * `MBD_CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] C2 =
    CNT_W'((`MBD_STEP_NS_2 * `MBD_CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] C3 =
    CNT_W'((`MBD_STEP_NS_3 * `MBD_CLK_MHZ + 999) / 1000);

  struct packed {
    logic [CNT_W-1:0] cnt;
  } s_q, s_d;
  logic [CNT_W-1:0] limit;

  // compare with >= so a shorter speed chosen mid-count cannot overrun
  always_comb begin
    unique case (speed_i)
      2'h0: limit = C0;
      2'h1: limit = C1;
      2'h2: limit = C2;
      2'h3: limit = C3;
    endcase
    tick_o = !restart_i && (s_q.cnt >= limit - CNT_W'(1));
    s_d.cnt = s_q.cnt + CNT_W'(1);
    if (restart_i || tick_o) begin
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// [hw/mbd_dvc_ctrl.sv]
// multiphase buck voltage control: targets, ramp, mode and phases
// assumes a classic wishbone master on clk_i and asynchronous pins
//
// Operation
// RQ1 - two targets held; the selected one is what the ramp aims at
// RQ2 - select comes from the pin or a register bit, per source bit
// RQ3 - writing the selected target starts a transition
// RQ4 - any change of the select starts a transition
// RQ5 - ramp moves 10 mV per 4, 2, 1 or 0.5 us interval
// RQ6 - forced pwm output high for the whole transition
// RQ7 - port three shows finish only when output and enabled
// RQ8 - default target comes from the otp input after reset
// RQ9 - trim moves oscillator 180 kHz and switching 90 kHz per step
// RQ10 - port four function selects the external 6 MHz clock
// RQ11 - mode field forces normal or low-power operation
// RQ12 - low-power phase count is one, two or four from otp
// RQ13 - low-power phase count cannot change once running
// RQ14 - auto mode: low power while target below threshold
// RQ15 - mode 00 takes low power flag from selected setting
// RQ16 - active phases follow the phase count select
// RQ17 - auto phase setting sheds phases by load current
// RQ18 - shedding only in normal mode, fixed count then ignored
// RQ19 - one device enables at most four, pair at most eight
// RQ20 - host learns status by reading the status register
// RQ21 - targets are clamped to the voltage ceiling
// RQ22 - each target stores its own low power flag
// RQ23 - one step per interval; done flagged when ramp meets target
// RQ24 - select pin synchronised before use
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "mbd_consts.svh"
module mbd_dvc_ctrl #(
  parameter logic [7:0] SHED_ONE_LIMIT = 8'h20,
  parameter logic [7:0] SHED_TWO_LIMIT = 8'h60
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        vsel_pin_i,
  input  wire logic        port_four_i,
  input  wire logic [7:0]  otp_default_code_i,
  input  wire logic [1:0]  otp_low_power_phases_i,
  input  wire logic [7:0]  load_current_i,
  output logic      [7:0]  vout_code_o,
  output logic             pwm_forced_o,
  output logic             low_power_o,
  output logic      [3:0]  phase_en_o,
  output logic             port_three_o,
  output logic             port_three_oe_o,
  output logic             ext_clock_sel_o,
  output logic      [13:0] osc_khz_o,
  output logic      [13:0] sw_khz_o
);
  mbd_pkg::mbd_state_type s_q, s_d;
  logic [1:0]  pins_sync;
  logic        tick;
  logic        start;
  logic        acc;
  logic        wr;
  logic        sel_now;
  logic [7:0]  tgt_raw;
  logic [7:0]  eff;
  logic [31:0] rd;
  logic [15:0] wv;
  mbd_pkg::mbd_mode_type  mode;
  mbd_pkg::mbd_phase_type phsel;

  // byte lanes 0 and 1 carry every writable register; status reads also use lane 2
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = dat[15:8];
    end
  endfunction

  // phase enables fill from phase 0 upward
  function automatic logic [3:0] phase_mask(input logic [1:0] n);
    case (n)
      2'h1:    phase_mask = 4'h3;
      2'h2:    phase_mask = 4'hF;
      default: phase_mask = 4'h1;
    endcase
  endfunction

  // select pin and external clock pin cross into clk_i here
  mbd_sync #(
    .W (2)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({port_four_i, vsel_pin_i}),
    .sync_o   (pins_sync)
  );

  mbd_step_timer #(
    .CNT_W (10)
  ) u_timer (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .restart_i (start),
    .speed_i   (s_q.cfg_one[3:2]),
    .tick_o    (tick)
  );

  // whole next-state: bus slave, targets, ramp, mode and phases
  always_comb begin
    s_d = s_q;
    acc = wb_cyc_i && wb_stb_i;
    // ack registered: write commits at the edge the master sees ack
    wr = acc && s_q.ack && wb_we_i;
    s_d.ack = acc && !s_q.ack;
    wv = 16'h0000;

    // read mux; unmapped addresses answer with zero
    case (wb_adr_i)
      `MBD_OFS_TARGET_A: rd = {23'h0, s_q.tva};
      `MBD_OFS_TARGET_B: rd = {23'h0, s_q.tvb};
      `MBD_OFS_CFG_MAIN: rd = {27'h0, s_q.cfg_main};
      `MBD_OFS_CFG_ONE:  rd = {28'h0, s_q.cfg_one};
      `MBD_OFS_CFG_TWO:  rd = {30'h0, s_q.cfg_two};
      `MBD_OFS_OSC_TRIM: rd = {27'h0, s_q.trim};
      `MBD_OFS_AUTO_TH:  rd = {24'h0, s_q.auto_th};
      `MBD_OFS_CEILING:  rd = {24'h0, s_q.ceil};
      // status lets the host poll the regulator RQ20
      `MBD_OFS_STATUS:   rd = {14'h0, s_q.ext_alive, s_q.ext, s_q.sel,
                               s_q.phases, s_q.lp, s_q.done, s_q.ramping,
                               s_q.ramp};
      default:           rd = 32'h0000_0000;
    endcase
    if (acc && !s_q.ack) begin
      s_d.dat = rd;
    end

    // register writes; status and unmapped offsets ignore them
    if (wr) begin
      unique case (wb_adr_i)
        `MBD_OFS_TARGET_A: begin
          wv = merge16({7'h0, s_q.tva}, wb_dat_i, wb_sel_i);
          s_d.tva = wv[8:0]; // RQ1 RQ22
        end
        `MBD_OFS_TARGET_B: begin
          wv = merge16({7'h0, s_q.tvb}, wb_dat_i, wb_sel_i);
          s_d.tvb = wv[8:0]; // RQ1 RQ22
        end
        `MBD_OFS_CFG_MAIN: begin
          wv = merge16({11'h0, s_q.cfg_main}, wb_dat_i, wb_sel_i);
          s_d.cfg_main = wv[4:0];
        end
        `MBD_OFS_CFG_ONE: begin
          wv = merge16({12'h0, s_q.cfg_one}, wb_dat_i, wb_sel_i);
          s_d.cfg_one = wv[3:0];
        end
        `MBD_OFS_CFG_TWO: begin
          wv = merge16({14'h0, s_q.cfg_two}, wb_dat_i, wb_sel_i);
          s_d.cfg_two = wv[1:0];
        end
        `MBD_OFS_OSC_TRIM: begin
          wv = merge16({11'h0, s_q.trim}, wb_dat_i, wb_sel_i);
          s_d.trim = wv[4:0];
        end
        `MBD_OFS_AUTO_TH: begin
          wv = merge16({8'h0, s_q.auto_th}, wb_dat_i, wb_sel_i);
          s_d.auto_th = wv[7:0];
        end
        `MBD_OFS_CEILING: begin
          wv = merge16({8'h0, s_q.ceil}, wb_dat_i, wb_sel_i);
          s_d.ceil = wv[7:0];
        end
        default: ;
      endcase
    end

    // select source: synchronised pin or software bit
    sel_now = s_q.cfg_main[`MBD_CM_SRC_BIT] ? pins_sync[0] // RQ2 RQ24
                                            : s_q.cfg_main[`MBD_CM_SEL_BIT];
    s_d.sel = sel_now;

    // a transition starts on select change or write to live target
    start = s_q.otp_done && ((sel_now != s_q.sel) // RQ4
            || (wr && (wb_adr_i == (s_q.sel ? `MBD_OFS_TARGET_B
                                            : `MBD_OFS_TARGET_A)))); // RQ3

    // clamp keeps a bad write from ever reaching the output
    tgt_raw = s_q.sel ? s_q.tvb[7:0] : s_q.tva[7:0]; // RQ1
    eff = (tgt_raw > s_q.ceil) ? s_q.ceil : tgt_raw; // RQ21

    // otp captured once after reset release, never again
    if (!s_q.otp_done) begin
      s_d.otp_done  = 1'b1;
      s_d.tva       = {1'b0, otp_default_code_i}; // RQ8
      s_d.tvb       = {1'b0, otp_default_code_i}; // RQ8
      s_d.ramp      = otp_default_code_i; // RQ8
      s_d.lp_phases = otp_low_power_phases_i; // RQ12 RQ13
    end else if (tick && (s_q.ramp != eff)) begin
      // one code step per interval toward the target
      if (s_q.ramp < eff) begin
        s_d.ramp = s_q.ramp + 8'(`MBD_STEP_MV / `MBD_CODE_MV); // RQ5 RQ23
      end else begin
        s_d.ramp = s_q.ramp - 8'(`MBD_STEP_MV / `MBD_CODE_MV); // RQ5 RQ23
      end
    end

    // done shows in the cycle the ramp value first equals the target
    s_d.ramping = start || (s_q.otp_done && (s_d.ramp != eff));
    s_d.done = s_q.ramping && !s_d.ramping; // RQ23
    s_d.pwm = s_d.ramping; // RQ6
    // next config, so the pin never lags the register that enables it
    s_d.p3_oe = s_d.cfg_main[`MBD_CM_P3_OUT_BIT]; // RQ7
    s_d.p3 = s_d.cfg_main[`MBD_CM_P3_OUT_BIT] // RQ7
             && s_d.cfg_main[`MBD_CM_DONE_EN_BIT] && !s_d.ramping;

    // operating mode
    mode = mbd_pkg::mbd_mode_type'(s_q.cfg_one[1:0]);
    unique case (mode)
      mbd_pkg::MBD_MODE_PER_SETTING:
        s_d.lp = s_q.sel ? s_q.tvb[`MBD_TV_LP_BIT] // RQ15 RQ22
                         : s_q.tva[`MBD_TV_LP_BIT];
      mbd_pkg::MBD_MODE_NORMAL:    s_d.lp = 1'b0; // RQ11
      mbd_pkg::MBD_MODE_LOW_POWER: s_d.lp = 1'b1; // RQ11
      mbd_pkg::MBD_MODE_AUTO:      s_d.lp = (eff < s_q.auto_th); // RQ14
    endcase

    // phase enables; never more than four so a pair stays within eight
    phsel = mbd_pkg::mbd_phase_type'(s_q.cfg_two);
    if (s_d.lp) begin
      s_d.phases = phase_mask(s_q.lp_phases); // RQ12
    end else begin
      unique case (phsel)
        mbd_pkg::MBD_PH_AUTO: begin
          if (load_current_i < SHED_ONE_LIMIT) begin
            s_d.phases = phase_mask(2'h0); // RQ17 RQ18
          end else if (load_current_i < SHED_TWO_LIMIT) begin
            s_d.phases = phase_mask(2'h1); // RQ17
          end else begin
            s_d.phases = phase_mask(2'h2); // RQ17 RQ19
          end
        end
        mbd_pkg::MBD_PH_ONE,
        mbd_pkg::MBD_PH_TWO,
        mbd_pkg::MBD_PH_FOUR: s_d.phases = phase_mask(s_q.cfg_two); // RQ16
      endcase
    end

    // frequency readback; trim is two's complement
    s_d.osc_khz = 14'(`MBD_OSC_NOM_KHZ
                  + `MBD_OSC_STEP_KHZ * int'($signed(s_q.trim))); // RQ9
    s_d.sw_khz = 14'(`MBD_OSC_NOM_KHZ / 2
                 + `MBD_SW_STEP_KHZ * int'($signed(s_q.trim))); // RQ9

    // external clock select and a sticky sign that edges arrive
    s_d.ext = s_q.cfg_main[`MBD_CM_P4_CLK_BIT]; // RQ10
    s_d.p4_prev = pins_sync[1];
    if (!s_d.ext) begin
      s_d.ext_alive = 1'b0;
    end else if (pins_sync[1] != s_q.p4_prev) begin
      s_d.ext_alive = 1'b1; // RQ10
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q          <= '0;
      s_q.cfg_main <= `MBD_RST_CFG_MAIN;
      s_q.cfg_one  <= `MBD_RST_CFG_ONE;
      s_q.cfg_two  <= `MBD_RST_CFG_TWO;
      s_q.trim     <= `MBD_RST_TRIM;
      s_q.auto_th  <= `MBD_RST_AUTO_TH;
      s_q.ceil     <= `MBD_RST_CEILING;
      s_q.phases   <= 4'hF;
    end else begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign wb_dat_o        = s_q.dat;
  assign wb_ack_o        = s_q.ack;
  assign vout_code_o     = s_q.ramp;
  assign pwm_forced_o    = s_q.pwm;
  assign low_power_o     = s_q.lp;
  assign phase_en_o      = s_q.phases;
  assign port_three_o    = s_q.p3;
  assign port_three_oe_o = s_q.p3_oe;
  assign ext_clock_sel_o = s_q.ext;
  assign osc_khz_o       = s_q.osc_khz;
  assign sw_khz_o        = s_q.sw_khz;

  // checks on the block's own behaviour
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  a_ack_answer: assert property (acc && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_step_size: assert property (s_q.otp_done && $past(s_q.otp_done) // RQ5
      && $changed(vout_code_o) |-> (vout_code_o == $past(vout_code_o)
      + 8'h01) || (vout_code_o == $past(vout_code_o) - 8'h01))
    else $error("ramp step not one code");
  a_step_spacing: assert property (s_q.otp_done && $past(s_q.otp_done) // RQ23
      && $changed(vout_code_o) |=> $stable(vout_code_o) [*8])
    else $error("ramp steps too close together");
  a_pwm_ramp: assert property (s_q.otp_done && $past(s_q.otp_done) // RQ6
      && $changed(vout_code_o) |-> $past(pwm_forced_o))
    else $error("output moved without forced pwm");
  a_sel_start: assert property (s_q.otp_done && $past(s_q.otp_done) // RQ4
      && $changed(s_q.sel) |-> pwm_forced_o)
    else $error("select change did not start a transition");
  a_ceiling: assert property (!pwm_forced_o && $stable(s_q.ceil) // RQ21
      && s_q.otp_done |-> vout_code_o <= s_q.ceil)
    else $error("settled output above ceiling");
  a_port_three: assert property (port_three_o |-> port_three_oe_o // RQ7
      && s_q.cfg_main[`MBD_CM_DONE_EN_BIT] && !pwm_forced_o)
    else $error("port three driven when not enabled");
  a_done_pulse: assert property ($fell(pwm_forced_o) // RQ23
      |-> s_q.done && vout_code_o == eff ##1 !s_q.done)
    else $error("done not one pulse at ramp end");
  a_otp_frozen: assert property (s_q.otp_done && $past(s_q.otp_done) // RQ13
      |-> $stable(s_q.lp_phases))
    else $error("low power phase count changed while running");
  a_phase_limit: assert property ( // RQ19
      $countones(phase_en_o) <= `MBD_DEV_PHASES
      && 2 * `MBD_DEV_PHASES <= `MBD_DUAL_MAX_PHASES && phase_en_o[0])
    else $error("phase enables out of range");
  a_shed_normal: assert property (low_power_o // RQ18
      |-> phase_en_o == phase_mask(s_q.lp_phases))
    else $error("phase shedding active in low power mode");
endmodule

// [sim/mbd_ext_clk_model.sv]
// outside clock source that stands at port four of the block
// assumes the bench raises en_i only while the clock function is wanted
`timescale 1ns/10ps
module mbd_ext_clk_model (
  input  wire logic en_i,
  output logic      clk_o
);
  // 6 MHz square wave; held low while disabled so that no stray edge
  // reaches the block's edge detector between uses
  initial begin
    clk_o = 1'b0;
    forever begin
      #83.333;
      clk_o = en_i ? ~clk_o : 1'b0;
    end
  end
endmodule

// [sim/tb_mbd_dvc_ctrl.sv]
// self-checking bench for the multiphase buck voltage control block
// assumes a classic wishbone slave that acks one cycle after a request
`timescale 1ns/10ps
`include "mbd_consts.svh"
module tb_mbd_dvc_ctrl;
  logic        clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, load_current_i, vout_code_o;
  logic [3:0]  wb_sel_i, phase_en_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic        vsel_pin_i, port_four_i, ext_en, pwm_forced_o, low_power_o;
  logic        port_three_o, port_three_oe_o, ext_clock_sel_o;
  logic [1:0]  otp_ph;
  logic [13:0] osc_khz_o, sw_khz_o;
  int          fail_count, checks, n, i;
  int          per_step[4] = '{500, 250, 125, 63};

  mbd_dvc_ctrl mbd_dvc_ctrl_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .vsel_pin_i(vsel_pin_i),
    .port_four_i(port_four_i), .otp_default_code_i(8'h40),
    .otp_low_power_phases_i(otp_ph), .load_current_i(load_current_i),
    .vout_code_o(vout_code_o), .pwm_forced_o(pwm_forced_o),
    .low_power_o(low_power_o), .phase_en_o(phase_en_o),
    .port_three_o(port_three_o), .port_three_oe_o(port_three_oe_o),
    .ext_clock_sel_o(ext_clock_sel_o), .osc_khz_o(osc_khz_o),
    .sw_khz_o(sw_khz_o));

  mbd_ext_clk_model mbd_ext_clk_model_inst (
    .en_i(ext_en), .clk_o(port_four_i));

  // free-running core clock, 8 ns period
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk_val(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, lo, hi, input string m);
    checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t %s count %0d", $time, m, got);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    chk_rng(k, 1, 19, "bus ack");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0);
    chk_val(rd, e, "read");
  endtask

  // follows one transition; cyc is the expected length in clocks
  task automatic ramp(input logic [7:0] code, input int cyc);
    repeat (2) @(posedge clk_i);
    chk_val(32'(pwm_forced_o), 32'h1, "pwm in ramp");
    chk_val(32'(port_three_o), 32'h0, "finish low");
    n = 2;
    while (vout_code_o !== code && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk_rng(n, cyc - 1, cyc + 3, "ramp time");
    repeat (2) @(posedge clk_i);
    chk_val(32'(pwm_forced_o), 32'h0, "pwm after");
    chk_val(32'(port_three_o), 32'h1, "finish flag");
  endtask

  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // cut a hang short well beyond the expected few thousand clocks
  initial begin
    #300000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    resetn_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    vsel_pin_i = 1'b1;
    ext_en = 1'b0;
    otp_ph = 2'h1;
    load_current_i = 8'h80;
    fail_count = 0;
    checks = 0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    // defaults after reset
    chk_val(32'(vout_code_o), 32'h40, "otp default");
    rd_chk(`MBD_OFS_TARGET_A, 32'h40);
    rd_chk(`MBD_OFS_CFG_ONE, 32'h1);
    rd_chk(`MBD_OFS_CFG_TWO, 32'h2);
    rd_chk(`MBD_OFS_AUTO_TH, 32'h50);
    rd_chk(`MBD_OFS_CEILING, 32'hFF);
    chk_val(32'(osc_khz_o), 32'd6000, "osc nominal");
    chk_val(32'(port_three_oe_o), 32'h0, "port three idle");
    wr(8'h24, 32'h5A);
    rd_chk(8'h24, 32'h0);
    // port three as output but finish flag disabled: held low
    wr(`MBD_OFS_CFG_MAIN, 32'h08);
    repeat (2) @(posedge clk_i);
    chk_val(32'(port_three_oe_o), 32'h1, "port three out");
    chk_val(32'(port_three_o), 32'h0, "flag disabled");
    wr(`MBD_OFS_CFG_MAIN, 32'h0C);
    // every ramp speed, one 10 mV step each
    for (i = 0; i < 4; i++) begin
      wr(`MBD_OFS_CFG_ONE, 32'(i * 4 + 1));
      wr(`MBD_OFS_TARGET_A, 32'(8'h41 + i));
      ramp(8'(8'h41 + i), per_step[i]);
    end
    // unselected target is quiet; register select switches over
    wr(`MBD_OFS_TARGET_B, 32'h48);
    repeat (3) @(posedge clk_i);
    chk_val(32'(pwm_forced_o), 32'h0, "quiet write");
    wr(`MBD_OFS_CFG_MAIN, 32'h0D);
    ramp(8'h48, 4 * 63);
    // hand select to the pin, then move back to A with it
    wr(`MBD_OFS_CFG_MAIN, 32'h0F);
    repeat (4) @(posedge clk_i);
    chk_val(32'(pwm_forced_o), 32'h0, "pin same level");
    vsel_pin_i <= 1'b0;
    @(posedge clk_i);
    chk_val(32'(pwm_forced_o), 32'h0, "pin not yet seen");
    // two sync stages plus the start edge before pwm can be seen
    @(posedge clk_i);
    ramp(8'h44, 4 * 63 + 3);
    // ceiling clamps a high target
    wr(`MBD_OFS_CEILING, 32'h46);
    wr(`MBD_OFS_TARGET_A, 32'h4F);
    ramp(8'h46, 2 * 63);
    wb_xfer(1'b0, `MBD_OFS_STATUS, 32'h0);
    chk_val(32'(rd[7:0]), 32'h46, "status code");
    // forced low power keeps the otp phase count
    wr(`MBD_OFS_CFG_ONE, 32'h0E);
    wr(`MBD_OFS_CFG_TWO, 32'h0);
    otp_ph <= 2'h2;
    repeat (3) @(posedge clk_i);
    chk_val(32'(low_power_o), 32'h1, "low power");
    chk_val(32'(phase_en_o), 32'h3, "lp phases");
    // normal mode: fixed counts, then shedding by load
    wr(`MBD_OFS_CFG_ONE, 32'h0D);
    for (i = 0; i < 3; i++) begin
      wr(`MBD_OFS_CFG_TWO, 32'(i));
      repeat (3) @(posedge clk_i);
      chk_val(32'(phase_en_o), 32'((1 << (1 << i)) - 1), "phases");
    end
    chk_val(32'(low_power_o), 32'h0, "normal");
    wr(`MBD_OFS_CFG_TWO, 32'h3);
    for (i = 0; i < 3; i++) begin
      load_current_i <= 8'(8'h10 + i * 8'h38);
      repeat (3) @(posedge clk_i);
      chk_val(32'(phase_en_o), 32'((1 << (1 << i)) - 1), "shed");
    end
    // automatic mode against the threshold
    wr(`MBD_OFS_CFG_ONE, 32'h0F);
    repeat (3) @(posedge clk_i);
    chk_val(32'(low_power_o), 32'h1, "auto low");
    chk_val(32'(phase_en_o), 32'h7 >> 1, "no shed in lp");
    wr(`MBD_OFS_AUTO_TH, 32'h40);
    repeat (3) @(posedge clk_i);
    chk_val(32'(low_power_o), 32'h0, "auto normal");
    // per-setting flag travels with the selected target
    wr(`MBD_OFS_CFG_ONE, 32'h0C);
    wr(`MBD_OFS_TARGET_A, 32'h146);
    wr(`MBD_OFS_TARGET_B, 32'h046);
    repeat (4) @(posedge clk_i);
    chk_val(32'(low_power_o), 32'h1, "flag A");
    vsel_pin_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk_val(32'(low_power_o), 32'h0, "flag B");
    // oscillator trim, signed steps
    wr(`MBD_OFS_OSC_TRIM, 32'h3);
    repeat (2) @(posedge clk_i);
    chk_val(32'(osc_khz_o), 32'd6540, "trim up");
    chk_val(32'(sw_khz_o), 32'd3270, "sw up");
    wr(`MBD_OFS_OSC_TRIM, 32'h1F);
    repeat (2) @(posedge clk_i);
    chk_val(32'(osc_khz_o), 32'd5820, "trim down");
    chk_val(32'(sw_khz_o), 32'd2910, "sw down");
    // external clock on port four
    ext_en <= 1'b1;
    wr(`MBD_OFS_CFG_MAIN, 32'h1F);
    repeat (100) @(posedge clk_i);
    chk_val(32'(ext_clock_sel_o), 32'h1, "ext select");
    wb_xfer(1'b0, `MBD_OFS_STATUS, 32'h0);
    chk_val(32'(rd[17]), 32'h1, "ext edges");
    wrap_up();
  end
endmodule
